// File: shared/ushdp_pkg.sv
// constants and carriers for the shadow data-port alias block
// assumes a 32-bit APB address space and a 125 MHz mclk
package ushdp_pkg;
  localparam logic [31:0] ALIAS7_ADDR     = 32'h5002_014C;
  localparam int          ALIAS7_INDEX    = 7;
  localparam int          ALIAS_COUNT     = 16;
  localparam logic [31:0] ALIAS_BASE      = ALIAS7_ADDR - 32'(ALIAS7_INDEX * 4);
  localparam logic [31:0] ALIAS_END       = ALIAS_BASE + 32'(ALIAS_COUNT * 4);
  localparam logic [31:0] LINE_STATUS_ADDR  = 32'h5002_0200;
  localparam logic [31:0] FIFO_CONTROL_ADDR = 32'h5002_0204;
  localparam logic [31:0] INT_STATUS_ADDR   = 32'h5002_0208;
  localparam logic [31:0] INT_MASK_ADDR     = 32'h5002_020C;
  // line_status fields
  localparam int LS_RX_VALID   = 0;
  localparam int LS_OVERRUN    = 1;
  localparam int LS_TX_EMPTY   = 5;
  // fifo_control fields
  localparam int FC_FIFO_EN    = 0;
  // int status / mask fields
  localparam int IS_RX_OVERRUN = 0;
  localparam int IS_TX_DROP    = 1;
  localparam int IS_RX_ARRIVE  = 2;
  localparam int IS_WIDTH      = 3;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam int          FIFO_DEPTH = 16;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ushdp_char_t;
endpackage : ushdp_pkg

// File: hw/ushdp_data_port.sv
// shadow data-port alias: sixteen apb words onto receive fifo and transmit fifo
// assumes receiver and serializer run on mclk; rx_char is a one-cycle strobe
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ushdp_fifo
  import ushdp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          single,
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [7:0]    push_data,
  input  wire logic          pop,
  output logic      [7:0]    head,
  output logic      [CW-1:0] count,
  output logic               overflow
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [7:0]    mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic          pop_eff;
  logic          wr_en;
  logic [PW-1:0] wr_addr;
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction
  assign head = mem[single ? '0 : rd_ptr];
  always_comb begin
    pop_eff     = pop && (count != '0);
    // fifo off: the one slot is always written, so the last char wins
    wr_en       = push && (single || (count != CW'(DEPTH)));
    wr_addr     = single ? '0 : wr_ptr;
    overflow    = push && (single ? (count != '0 && !pop_eff) : (count == CW'(DEPTH)));
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end else if (single) begin
      if (push) begin
        next_count = CW'(1);
      end else if (pop_eff) begin
        next_count = '0;
      end
    end else begin
      if (wr_en) begin
        next_wr_ptr = ptr_inc(wr_ptr);
      end
      if (pop_eff) begin
        next_rd_ptr = ptr_inc(rd_ptr);
      end
      next_count = CW'(count + CW'(wr_en) - CW'(pop_eff));
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
  // storage clears on reset so an early alias read shows the reset byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem <= '{default: 8'h00};
    end else if (wr_en && !flush) begin
      mem[wr_addr] <= push_data;
    end
  end
endmodule : ushdp_fifo

////////////////////////////////////////////////////////////////////////////////
module ushdp_data_port
  import ushdp_pkg::*;
#(
  parameter int RX_DEPTH = FIFO_DEPTH,
  parameter int TX_DEPTH = FIFO_DEPTH
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire ushdp_char_t rx_char,
  input  wire logic        tx_req,
  output ushdp_char_t      tx_char,
  output logic             irq
);
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } ushdp_state_t;
  logic                rst_meta_n;
  logic                rst_sync_n;
  ushdp_state_t        state;
  ushdp_state_t        next_state;
  logic [31:0]         next_prdata;
  logic                next_pslverr;
  logic                fifo_en;
  logic                next_fifo_en;
  logic                ls_overrun;
  logic                next_ls_overrun;
  logic [IS_WIDTH-1:0] int_status;
  logic [IS_WIDTH-1:0] next_int_status;
  logic [IS_WIDTH-1:0] int_mask;
  logic [IS_WIDTH-1:0] next_int_mask;
  ushdp_char_t         next_tx_char;
  logic                next_irq;
  logic                done;
  logic                rd_done;
  logic                wr_done;
  logic                alias_sel;
  logic                flush;
  logic                rx_pop;
  logic                tx_push;
  logic                tx_pop;
  logic [7:0]          rx_head;
  logic [7:0]          tx_head;
  logic [RCW-1:0]      rx_count;
  logic [TCW-1:0]      tx_count;
  logic                rx_overflow;
  logic                tx_overflow;
  logic                rx_valid_flag;
  logic                tx_empty_flag;
  logic [31:0]         line_status_word;
  function automatic logic is_alias(input logic [31:0] a);
    is_alias = (a >= ALIAS_BASE) && (a < ALIAS_END) && (a[1:0] == 2'b00);
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data path
  assign alias_sel     = is_alias(paddr);
  assign done          = psel && penable && pready;
  assign rd_done       = done && !pwrite && alias_sel;
  assign wr_done       = done && pwrite && alias_sel && pstrb[0];
  assign rx_valid_flag = (rx_count != '0);
  assign tx_empty_flag = (tx_count != '0) ? 1'b0 : 1'b1;
  // popping an empty receiver is ignored, the flag decides what counts
  assign rx_pop        = rd_done && rx_valid_flag;
  assign tx_push       = wr_done;
  assign tx_pop        = tx_req && (tx_count != '0);
  // switching fifo mode empties both sides so no stale char leaks across
  assign flush         = done && pwrite && (paddr == FIFO_CONTROL_ADDR) && pstrb[0]
                         && (pwdata[FC_FIFO_EN] != fifo_en);

  ushdp_fifo #(
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk       (mclk),
    .rst_n     (rst_sync_n),
    .single    (!fifo_en),
    .flush     (flush),
    .push      (rx_char.valid),
    .push_data (rx_char.data),
    .pop       (rx_pop),
    .head      (rx_head),
    .count     (rx_count),
    .overflow  (rx_overflow)
  );
  ushdp_fifo #(
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk       (mclk),
    .rst_n     (rst_sync_n),
    .single    (!fifo_en),
    .flush     (flush),
    .push      (tx_push),
    .push_data (pwdata[7:0]),
    .pop       (tx_pop),
    .head      (tx_head),
    .count     (tx_count),
    .overflow  (tx_overflow)
  );
  always_comb begin
    line_status_word              = '0;
    line_status_word[LS_RX_VALID] = rx_valid_flag;
    line_status_word[LS_OVERRUN]  = ls_overrun;
    line_status_word[LS_TX_EMPTY] = tx_empty_flag;
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer registered
  always_comb begin
    next_state   = state;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    unique case (state)
      ST_IDLE: begin
        if (psel && penable) begin
          next_state   = ST_ACK;
          next_prdata  = '0;
          next_pslverr = 1'b0;
          if (alias_sel) begin
            // stale byte is shown when empty; the flag tells it apart
            next_prdata[7:0] = pwrite ? 8'h00 : rx_head;
          end else if (paddr == LINE_STATUS_ADDR) begin
            next_prdata = pwrite ? '0 : line_status_word;
          end else if (paddr == FIFO_CONTROL_ADDR) begin
            next_prdata[FC_FIFO_EN] = pwrite ? 1'b0 : fifo_en;
          end else if (paddr == INT_STATUS_ADDR) begin
            next_prdata[IS_WIDTH-1:0] = pwrite ? '0 : int_status;
          end else if (paddr == INT_MASK_ADDR) begin
            next_prdata[IS_WIDTH-1:0] = pwrite ? '0 : int_mask;
          end else begin
            next_pslverr = 1'b1;
          end
        end
      end
      ST_ACK: begin
        next_state   = ST_IDLE;
        next_prdata  = '0;
        next_pslverr = 1'b0;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state   <= ST_IDLE;
      pready  <= 1'b0;
      prdata  <= DATA_RESET;
      pslverr <= 1'b0;
    end else begin
      state   <= next_state;
      pready  <= (next_state == ST_ACK);
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control, status, interrupts, transmit hand-off
  always_comb begin
    next_fifo_en    = fifo_en;
    next_int_mask   = int_mask;
    next_int_status = int_status;
    next_ls_overrun = ls_overrun;
    if (done && pwrite && pstrb[0]) begin
      if (paddr == FIFO_CONTROL_ADDR) begin
        next_fifo_en = pwdata[FC_FIFO_EN];
      end
      if (paddr == INT_MASK_ADDR) begin
        next_int_mask = pwdata[IS_WIDTH-1:0];
      end
      if (paddr == INT_STATUS_ADDR) begin
        next_int_status = int_status & ~pwdata[IS_WIDTH-1:0];
      end
    end
    if (done && !pwrite && (paddr == LINE_STATUS_ADDR)) begin
      next_ls_overrun = 1'b0;
    end
    // sets come last so an event in the clearing cycle survives
    if (rx_overflow) begin
      next_ls_overrun                = 1'b1;
      next_int_status[IS_RX_OVERRUN] = 1'b1;
    end
    if (tx_overflow && fifo_en) begin
      next_int_status[IS_TX_DROP] = 1'b1;
    end
    if (rx_char.valid) begin
      next_int_status[IS_RX_ARRIVE] = 1'b1;
    end
    next_irq          = |(next_int_status & next_int_mask);
    next_tx_char.valid = tx_pop;
    next_tx_char.data  = tx_pop ? tx_head : tx_char.data;
  end
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fifo_en    <= 1'b0;
      int_mask   <= '0;
      int_status <= '0;
      ls_overrun <= 1'b0;
      irq        <= 1'b0;
      tx_char    <= '0;
    end else begin
      fifo_en    <= next_fifo_en;
      int_mask   <= next_int_mask;
      int_status <= next_int_status;
      ls_overrun <= next_ls_overrun;
      irq        <= next_irq;
      tx_char    <= next_tx_char;
    end
  end
endmodule : ushdp_data_port

`default_nettype wire

// File: sim/ushdp_props.sv
// checker for the shadow data-port alias block
// assumes a bind onto ushdp_data_port, one mclk domain
`timescale 1ns/1ps
`default_nettype none
module ushdp_props
  import ushdp_pkg::*;
#(
  parameter int RX_DEPTH = FIFO_DEPTH,
  parameter int TX_DEPTH = FIFO_DEPTH
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [31:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire ushdp_char_t rx_char,
  input wire logic        tx_req,
  input wire ushdp_char_t tx_char,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign hit = paddr >= ALIAS_BASE && paddr < ALIAS_END && paddr[1:0] == 2'b00;
  property p_rdy; acc && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access not answered");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_cause; pready |-> $past(acc); endproperty
  a_cause: assert property (p_cause) else $error("ready without access");
  property p_alias; pready && hit |-> !pslverr; endproperty
  a_alias: assert property (p_alias) else $error("alias word refused");
  property p_upper; pready && !pwrite |-> (prdata >> 8) == 32'h0000_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error without clean answer");
  property p_txv; tx_char.valid |-> $past(tx_req); endproperty
  a_txv: assert property (p_txv) else $error("char sent unasked");
  property p_txd; !tx_char.valid |-> $stable(tx_char.data); endproperty
  a_txd: assert property (p_txd) else $error("tx data moved while idle");
  c_read: cover property (pready && hit && !pwrite);
  c_err: cover property (pslverr);
  c_tx: cover property (tx_char.valid);
  c_irq: cover property (irq);
endmodule // ushdp_props
`default_nettype wire

// File: sim/ushdp_far_end.sv
// far-end model: receiver strobing bytes in, serializer pulling them out
// assumes the data port's mclk
`timescale 1ns/1ps
`default_nettype none
module ushdp_far_end
  import ushdp_pkg::*;
(
  input  wire logic        mclk,
  output var ushdp_char_t  rx_char,
  output var logic         tx_req,
  input  wire ushdp_char_t tx_char
);
  initial begin
    rx_char = '0;
    tx_req  = 1'b0;
  end
  // idle byte is the inverse so stale data never looks right
  task automatic send(input logic [7:0] d);
    @(posedge mclk);
    rx_char <= '{valid: 1'b1, data: d};
    @(posedge mclk);
    rx_char <= '{valid: 1'b0, data: ~d};
  endtask
  task automatic pull(output logic v, output logic [7:0] d);
    @(posedge mclk);
    tx_req <= 1'b1;
    @(posedge mclk);
    tx_req <= 1'b0;
    @(posedge mclk);
    v = tx_char.valid;
    d = tx_char.data;
  endtask
endmodule // ushdp_far_end
`default_nettype wire

// File: sim/uart_shadow_data_port_bench.sv
// bench for the shadow data-port alias block over apb
// assumes ushdp_props and ushdp_far_end beside it
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_data_port_bench;
  import ushdp_pkg::*;
  localparam int D = 16;
  logic        mclk = 1'b0;
  logic        rst_n, psel, penable, pwrite, pready, pslverr, tx_req, irq, tv, re;
  logic [31:0] paddr, pwdata, prdata, rv;
  logic [3:0]  pstrb;
  logic [7:0]  td;
  ushdp_char_t rx_char, tx_char;
  int          failures = 0;
  int          checks = 0;
  always #4 mclk = ~mclk;
  ushdp_data_port #(.RX_DEPTH(D), .TX_DEPTH(D)) i_ushdp_data_port (.mclk(mclk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_char(rx_char), .tx_req(tx_req),
    .tx_char(tx_char), .irq(irq));
  ushdp_far_end i_ushdp_far_end (.mclk(mclk), .rx_char(rx_char), .tx_req(tx_req), .tx_char(tx_char));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // request stands until pready is sampled high at a rising edge
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("read %h", a), rv, e);
  endtask
  task automatic get(input logic v, input logic [7:0] e);
    i_ushdp_far_end.pull(tv, td);
    chk("tx valid", 32'(tv), 32'(v));
    if (v)
      chk("tx data", 32'(td), 32'(e));
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100_000;
    failures++;
    give_verdict();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(LINE_STATUS_ADDR, 32'h0000_0020);
    rd(FIFO_CONTROL_ADDR, 32'h0000_0000);
    rd(INT_MASK_ADDR, 32'h0000_0000);
    rd(ALIAS7_ADDR, DATA_RESET);
    apb(1'b0, ALIAS_BASE - 32'h0000_0004, 32'h0000_0000);
    chk("slave error", 32'(re), 32'h0000_0001);
    $display("reset test done");
    apb(1'b1, INT_MASK_ADDR, 32'h0000_0001);
    i_ushdp_far_end.send(8'h5A);
    rd(LINE_STATUS_ADDR, 32'h0000_0021);
    i_ushdp_far_end.send(8'hA5);
    rd(LINE_STATUS_ADDR, 32'h0000_0023);
    chk("irq", 32'(irq), 32'h0000_0001);
    rd(ALIAS_BASE + 32'h0000_000C, 32'h0000_00A5);
    rd(LINE_STATUS_ADDR, 32'h0000_0020);
    rd(INT_STATUS_ADDR, 32'h0000_0005);
    apb(1'b1, INT_STATUS_ADDR, 32'h0000_0007);
    i_ushdp_far_end.send(8'h3C);
    rd(INT_STATUS_ADDR, 32'h0000_0004);
    chk("irq", 32'(irq), 32'h0000_0000);
    rd(ALIAS_BASE, 32'h0000_003C);
    $display("single receive test done");
    apb(1'b1, ALIAS_BASE, 32'hFFFF_FF11);
    rd(LINE_STATUS_ADDR, 32'h0000_0000);
    apb(1'b1, ALIAS_END - 32'h0000_0004, 32'h0000_0022);
    pstrb <= 4'hE;
    apb(1'b1, ALIAS_BASE, 32'h0000_0033);
    pstrb <= 4'hF;
    get(1'b1, 8'h22);
    get(1'b0, 8'h00);
    rd(LINE_STATUS_ADDR, 32'h0000_0020);
    $display("single transmit test done");
    apb(1'b1, FIFO_CONTROL_ADDR, 32'h0000_0001);
    for (int i = 0; i <= D; i++) i_ushdp_far_end.send(8'(i));
    rd(INT_STATUS_ADDR, 32'h0000_0005);
    for (int i = 0; i < D; i++) rd(ALIAS_BASE + 32'(4 * i), 32'(i));
    rd(LINE_STATUS_ADDR, 32'h0000_0022);
    apb(1'b1, INT_STATUS_ADDR, 32'h0000_0007);
    for (int i = 0; i <= D; i++) apb(1'b1, ALIAS_BASE, 32'(8'h80 + i));
    rd(INT_STATUS_ADDR, 32'h0000_0002);
    for (int i = 0; i < D; i++) get(1'b1, 8'(8'h80 + i));
    get(1'b0, 8'h00);
    rd(LINE_STATUS_ADDR, 32'h0000_0020);
    $display("fifo test done");
    give_verdict();
  end
endmodule // uart_shadow_data_port_bench
bind ushdp_data_port ushdp_props #(.RX_DEPTH(RX_DEPTH), .TX_DEPTH(TX_DEPTH)) i_ushdp_props (.mclk(mclk),
  .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_char(rx_char),
  .tx_req(tx_req), .tx_char(tx_char), .irq(irq));
`default_nettype wire
